/* common/upf_cfg.svh */
// offsets, field positions, reset values and timing counts for the under power factor stage
`ifndef UPF_CFG_SVH
`define UPF_CFG_SVH

// timing
`define UPF_CLK_NS 50
`define UPF_CYCLE_US 5000
`define UPF_TICKW 20
`define UPF_BLOCK_LEAD_MS 5
`define UPF_HIST 40
`define UPF_PRE_TAP 3
`define UPF_NREC 12
`define UPF_NEVT 5

// fixed hysteresis and scale, in percent
`define UPF_HYST_PCT 16'h0067
`define UPF_PCT 16'h0064

// event bit positions
`define EV_BLOCK 0
`define EV_START 1
`define EV_TRIP 2
`define EV_ASTART 3
`define EV_ALARM 4

// record event codes
`define REC_START 2'h1
`define REC_TRIP 2'h2
`define REC_BLOCK 2'h3

// register byte addresses
`define UPF_A_CTRL 8'h00
`define UPF_A_TRIP_SET 8'h04
`define UPF_A_ALARM_SET 8'h08
`define UPF_A_TRIP_DLY 8'h0C
`define UPF_A_ALARM_DLY 8'h10
`define UPF_A_EVT_EN 8'h14
`define UPF_A_STATUS 8'h18
`define UPF_A_CNT_CLR 8'h1C
`define UPF_A_CNT0 8'h20
`define UPF_A_CNT1 8'h24
`define UPF_A_CNT2 8'h28
`define UPF_A_CNT3 8'h2C
`define UPF_A_CNT4 8'h30
`define UPF_A_EXP_OP 8'h34
`define UPF_A_REM_TRIP 8'h38
`define UPF_A_EXP_ALM 8'h3C
`define UPF_A_REM_ALM 8'h40
`define UPF_A_RATIO_TRIP 8'h44
`define UPF_A_RATIO_ALM 8'h48
`define UPF_A_REC_SEL 8'h4C
`define UPF_A_REC_TIME 8'h50
`define UPF_A_REC_PF 8'h54
`define UPF_A_REC_INFO 8'h58

// reset values
`define UPF_RST_ALARM_EN 1'b1
`define UPF_RST_TRIP_SET 8'h50
`define UPF_RST_ALARM_SET 8'h5A
`define UPF_RST_DLY 16'h0014
`define UPF_RST_EVT_EN 10'h3FF

`endif

/* common/upf_pkg.sv */
// types shared by the under power factor stage modules
`include "upf_cfg.svh"
package upf_pkg;

  typedef enum logic [2:0] {
    MODE_ON = 3'b000,
    MODE_BLOCKED = 3'b001,
    MODE_TEST = 3'b010,
    MODE_TEST_BLOCKED = 3'b011,
    MODE_OFF = 3'b100
  } mode_t;

  typedef enum logic [2:0] {
    COND_NORMAL = 3'b000,
    COND_START = 3'b001,
    COND_TRIP = 3'b010,
    COND_BLOCKED = 3'b011,
    COND_ALARM_START = 3'b100,
    COND_ALARM = 3'b101
  } cond_t;

  // definite-time stage: running, expired, elapsed processing cycles
  typedef struct packed {
    logic run;
    logic done;
    logic [15:0] tmr;
  } stage_t;

  typedef struct packed {
    logic [31:0] time_ms;
    logic [1:0] code;
    logic [7:0] pre_pf;
    logic [7:0] fault_pf;
    logic [7:0] prefault_pf;
    logic [15:0] remain;
    logic [2:0] group;
  } rec_t;

endpackage

/* rtl/pf_ratio.sv */
// measured power factor over a pick-up setting, in hundredths
`timescale 1ns/1ps
`include "upf_cfg.svh"
module pf_ratio import upf_pkg::*; (
  input wire logic clk_i,           // system clock
  input wire logic rstn_i,          // synchronous reset, active low
  input wire logic [7:0] pf_i,      // measured power factor, hundredths
  input wire logic [7:0] set_i,     // pick-up setting, hundredths
  output logic [15:0] ratio_o       // ratio, hundredths
);
  typedef struct packed {
    logic [15:0] ratio;
  } pr_state_t;

  pr_state_t s;
  pr_state_t next_s;

  // a zero setting saturates rather than dividing by zero
  always_comb begin
    next_s = s;
    if (set_i == 8'h00) begin
      next_s.ratio = 16'hFFFF;
    end else begin
      next_s.ratio = 16'({8'h00, pf_i} * `UPF_PCT / {8'h00, set_i});
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ratio_o = s.ratio;
endmodule

/* rtl/fault_store.sv */
// circular store of the newest fault records
`timescale 1ns/1ps
`include "upf_cfg.svh"
module fault_store import upf_pkg::*; #(
  parameter int DEPTH = `UPF_NREC
) (
  input wire logic clk_i,           // system clock
  input wire logic rstn_i,          // synchronous reset, active low
  input wire logic wr_i,            // write one record, pulse
  input wire rec_t rec_i,           // record to write
  input wire logic [3:0] sel_i,     // record index to read, raw slot number; slot 0 is rewritten first once the store wraps
  output rec_t rec_o                // selected record, registered
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [AW-1:0] wptr;
    rec_t [DEPTH-1:0] mem;
    rec_t rd;
  } fs_state_t;

  fs_state_t s;
  fs_state_t next_s;

  // write pointer wraps, so a full store loses its oldest slot first
  always_comb begin
    next_s = s;
    if (wr_i) begin
      next_s.mem[s.wptr] = rec_i;
      next_s.wptr = (s.wptr == LAST) ? '0 : AW'(s.wptr + 1'b1);
    end
    next_s.rd = (sel_i < 4'(DEPTH)) ? s.mem[sel_i[AW-1:0]] : '0;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rec_o = s.rd;
endmodule

/* rtl/under_power_factor_stage.sv */
// under power factor stage: pick-up, blocking, definite-time timing, events, counters, apb registers
`timescale 1ns/1ps
`include "upf_cfg.svh"
module under_power_factor_stage import upf_pkg::*; #(
  parameter int TICK_CYC = `UPF_CYCLE_US * 1000 / `UPF_CLK_NS
) (
  input wire logic clk_i,              // system clock, 20 MHz
  input wire logic rstn_i,             // synchronous reset, active low
  input wire logic psel_i,             // apb select
  input wire logic penable_i,          // apb enable
  input wire logic pwrite_i,           // apb write
  input wire logic [7:0] paddr_i,      // apb byte address
  input wire logic [31:0] pwdata_i,    // apb write data
  output logic [31:0] prdata_o,        // apb read data
  output logic pready_o,               // apb ready
  output logic pslverr_o,              // apb error on unmapped address
  input wire logic block_i,            // block from the blocking matrix
  input wire logic [7:0] pf_i,         // three phase power factor, hundredths
  input wire logic [31:0] time_ms_i,   // device time stamp, ms
  input wire logic [2:0] sgroup_i,     // active setting group
  output logic start_o,                // start
  output logic trip_o,                 // trip
  output logic blocked_o,              // blocked
  output logic alarm_start_o,          // alarm start
  output logic alarm_o,                // alarm
  output logic [4:0] evt_on_o,         // enabled ON events, pulse
  output logic [4:0] evt_off_o,        // enabled OFF events, pulse
  output logic [31:0] evt_time_o       // time stamp of the event pulses
);
  localparam logic [`UPF_TICKW-1:0] TICK_LAST = `UPF_TICKW'(TICK_CYC - 1);

  typedef struct packed {
    logic [`UPF_TICKW-1:0] tick_cnt;
    mode_t mode;
    logic alarm_en;
    logic [7:0] trip_set;
    logic [7:0] alarm_set;
    logic [15:0] trip_dly;
    logic [15:0] alarm_dly;
    logic [9:0] evt_en;
    logic [3:0] rec_sel;
    logic pu_t;
    logic pu_a;
    stage_t tr;
    stage_t al;
    logic blocked;
    logic [4:0] prev;
    logic [4:0][15:0] cnt;
    logic [`UPF_HIST-1:0][7:0] hist;
    logic [7:0] pf200;
    logic rec_wr;
    rec_t rec;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] evt_on;
    logic [4:0] evt_off;
    logic [31:0] evt_time;
  } st_t;

  st_t s;
  st_t next_s;
  rec_t rec_rd;
  logic [15:0] ratio_trip;
  logic [15:0] ratio_alm;

  // the two blocking modes act like a permanently active block input
  function automatic logic mode_blocks(input mode_t m);
    return (m == MODE_BLOCKED) || (m == MODE_TEST_BLOCKED);
  endfunction

  // pick-up below the setting, release only at or above the hysteresis level
  function automatic logic pickup(input logic was, input logic [7:0] pf, input logic [7:0] set);
    logic [15:0] pf_scaled;
    logic [15:0] rel_lvl;
    pf_scaled = 16'({8'h00, pf} * `UPF_PCT);
    rel_lvl = 16'({8'h00, set} * `UPF_HYST_PCT);
    if (was) begin
      return !(pf_scaled >= rel_lvl);
    end
    return pf < set;
  endfunction

  // one processing cycle of a definite-time stage; no go means instant release
  function automatic stage_t dt_step(input stage_t st, input logic go, input logic [15:0] dly);
    stage_t r;
    r = '0;
    if (go) begin
      r.run = 1'b1;
      r.tmr = (!st.run) ? 16'h0000 : ((st.tmr == 16'hFFFF) ? st.tmr : 16'(st.tmr + 1'b1));
      r.done = st.run && (17'(st.tmr) + 17'h00001 >= {1'b0, dly});
    end
    return r;
  endfunction

  // time left on a running stage, zero once expired or idle
  function automatic logic [15:0] remaining(input stage_t st, input logic [15:0] dly);
    if (st.run && !st.done && dly > st.tmr) begin
      return 16'(dly - st.tmr);
    end
    return 16'h0000;
  endfunction

  // displayed condition, most severe first
  function automatic cond_t cond_of(input st_t st);
    if (st.tr.done) begin
      return COND_TRIP;
    end
    if (st.tr.run) begin
      return COND_START;
    end
    if (st.al.done) begin
      return COND_ALARM;
    end
    if (st.al.run) begin
      return COND_ALARM_START;
    end
    if (st.blocked) begin
      return COND_BLOCKED;
    end
    return COND_NORMAL;
  endfunction

  pf_ratio u_ratio_trip (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pf_i(pf_i),
    .set_i(s.trip_set),
    .ratio_o(ratio_trip)
  );

  pf_ratio u_ratio_alm (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pf_i(pf_i),
    .set_i(s.alarm_set),
    .ratio_o(ratio_alm)
  );

  fault_store #(
    .DEPTH(`UPF_NREC)
  ) u_store (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_i(s.rec_wr),
    .rec_i(s.rec),
    .sel_i(s.rec_sel),
    .rec_o(rec_rd)
  );

  // processing cycle, pick-up, blocking, stage timing, events, counters and bus
  always_comb begin
    logic tick;
    logic blk;
    logic act;
    logic pu_t;
    logic pu_a;
    logic [4:0] cur;
    logic [4:0] rise;
    logic [4:0] fall;
    logic [4:0] clr;
    logic wr;
    logic [31:0] rd;
    logic hit;
    tick = 1'b0;
    blk = 1'b0;
    act = 1'b0;
    pu_t = 1'b0;
    pu_a = 1'b0;
    cur = '0;
    rise = '0;
    fall = '0;
    clr = '0;
    wr = 1'b0;
    rd = 32'h0000_0000;
    hit = 1'b0;
    next_s = s;
    next_s.rec_wr = 1'b0;
    next_s.evt_on = '0;
    next_s.evt_off = '0;

    // processing cycle base
    tick = (s.tick_cnt == TICK_LAST);
    next_s.tick_cnt = tick ? '0 : `UPF_TICKW'(s.tick_cnt + 1'b1);

    // bus writes land on the completing access edge
    wr = psel_i && penable_i && s.pready && pwrite_i;
    if (wr) begin
      unique case (paddr_i)
        `UPF_A_CTRL: begin
          next_s.mode = (pwdata_i[2:0] > MODE_OFF) ? MODE_OFF : mode_t'(pwdata_i[2:0]);
          next_s.alarm_en = pwdata_i[3];
        end
        `UPF_A_TRIP_SET: next_s.trip_set = pwdata_i[7:0];
        `UPF_A_ALARM_SET: next_s.alarm_set = pwdata_i[7:0];
        `UPF_A_TRIP_DLY: next_s.trip_dly = pwdata_i[15:0];
        `UPF_A_ALARM_DLY: next_s.alarm_dly = pwdata_i[15:0];
        `UPF_A_EVT_EN: next_s.evt_en = pwdata_i[9:0];
        `UPF_A_CNT_CLR: clr = pwdata_i[4:0];
        `UPF_A_REC_SEL: next_s.rec_sel = pwdata_i[3:0];
        default: ;
      endcase
    end

    // clearing a counter happens first, so an occurrence in the same cycle still counts
    for (int i = 0; i < `UPF_NEVT; i++) begin
      if (clr[i]) begin
        next_s.cnt[i] = 16'h0000;
      end
    end

    if (tick) begin
      // block is taken once per cycle, before any timing decision
      blk = block_i || mode_blocks(s.mode);
      act = (s.mode != MODE_OFF);
      pu_t = act && pickup(s.pu_t, pf_i, s.trip_set);
      pu_a = act && s.alarm_en && pickup(s.pu_a, pf_i, s.alarm_set);
      next_s.pu_t = pu_t;
      next_s.pu_a = pu_a;

      // a block during start drops the go condition, which releases like a pick-up drop
      next_s.tr = dt_step(s.tr, pu_t && !blk, s.trip_dly);
      next_s.al = dt_step(s.al, pu_a && !blk, s.alarm_dly);
      next_s.blocked = (pu_t || pu_a) && blk;

      // edges of the five outputs, filtered by the per-event enables
      cur[`EV_BLOCK] = next_s.blocked;
      cur[`EV_START] = next_s.tr.run;
      cur[`EV_TRIP] = next_s.tr.done;
      cur[`EV_ASTART] = next_s.al.run;
      cur[`EV_ALARM] = next_s.al.done;
      rise = cur & ~s.prev;
      fall = ~cur & s.prev;
      next_s.prev = cur;
      next_s.evt_on = rise & s.evt_en[4:0];
      next_s.evt_off = fall & s.evt_en[9:5];
      next_s.evt_time = time_ms_i;
      for (int i = 0; i < `UPF_NEVT; i++) begin
        if (rise[i]) begin
          next_s.cnt[i] = 16'(next_s.cnt[i] + 1'b1);
        end
      end

      // pre-fault level is frozen at start and reused by a later trip record
      if (rise[`EV_START]) begin
        next_s.pf200 = s.hist[`UPF_HIST-1];
      end
      if (rise[`EV_START] || rise[`EV_TRIP] || rise[`EV_BLOCK]) begin
        next_s.rec_wr = 1'b1;
        next_s.rec.time_ms = time_ms_i;
        next_s.rec.code = rise[`EV_TRIP] ? `REC_TRIP : (rise[`EV_START] ? `REC_START : `REC_BLOCK);
        next_s.rec.pre_pf = s.hist[`UPF_PRE_TAP];
        next_s.rec.fault_pf = pf_i;
        next_s.rec.prefault_pf = rise[`EV_START] ? s.hist[`UPF_HIST-1] : s.pf200;
        next_s.rec.remain = remaining(next_s.tr, s.trip_dly);
        next_s.rec.group = sgroup_i;
      end
      next_s.hist = {s.hist[`UPF_HIST-2:0], pf_i};
    end

    // read data is captured in the setup cycle so the access cycle answers from flops
    unique case (paddr_i)
      `UPF_A_CTRL: begin
        rd = {28'h0000000, s.alarm_en, s.mode};
        hit = 1'b1;
      end
      `UPF_A_TRIP_SET: begin
        rd = {24'h000000, s.trip_set};
        hit = 1'b1;
      end
      `UPF_A_ALARM_SET: begin
        rd = {24'h000000, s.alarm_set};
        hit = 1'b1;
      end
      `UPF_A_TRIP_DLY: begin
        rd = {16'h0000, s.trip_dly};
        hit = 1'b1;
      end
      `UPF_A_ALARM_DLY: begin
        rd = {16'h0000, s.alarm_dly};
        hit = 1'b1;
      end
      `UPF_A_EVT_EN: begin
        rd = {22'h000000, s.evt_en};
        hit = 1'b1;
      end
      `UPF_A_STATUS: begin
        rd = {25'h0000000, s.mode, 1'b0, cond_of(s)};
        hit = 1'b1;
      end
      `UPF_A_CNT_CLR: hit = 1'b1;
      `UPF_A_CNT0: begin
        rd = {16'h0000, s.cnt[0]};
        hit = 1'b1;
      end
      `UPF_A_CNT1: begin
        rd = {16'h0000, s.cnt[1]};
        hit = 1'b1;
      end
      `UPF_A_CNT2: begin
        rd = {16'h0000, s.cnt[2]};
        hit = 1'b1;
      end
      `UPF_A_CNT3: begin
        rd = {16'h0000, s.cnt[3]};
        hit = 1'b1;
      end
      `UPF_A_CNT4: begin
        rd = {16'h0000, s.cnt[4]};
        hit = 1'b1;
      end
      `UPF_A_EXP_OP: begin
        rd = {16'h0000, s.trip_dly};
        hit = 1'b1;
      end
      `UPF_A_REM_TRIP: begin
        rd = {16'h0000, remaining(s.tr, s.trip_dly)};
        hit = 1'b1;
      end
      `UPF_A_EXP_ALM: begin
        rd = {16'h0000, s.alarm_dly};
        hit = 1'b1;
      end
      `UPF_A_REM_ALM: begin
        rd = {16'h0000, remaining(s.al, s.alarm_dly)};
        hit = 1'b1;
      end
      `UPF_A_RATIO_TRIP: begin
        rd = {16'h0000, ratio_trip};
        hit = 1'b1;
      end
      `UPF_A_RATIO_ALM: begin
        rd = {16'h0000, ratio_alm};
        hit = 1'b1;
      end
      `UPF_A_REC_SEL: begin
        rd = {28'h0000000, s.rec_sel};
        hit = 1'b1;
      end
      `UPF_A_REC_TIME: begin
        rd = rec_rd.time_ms;
        hit = 1'b1;
      end
      `UPF_A_REC_PF: begin
        rd = {8'h00, rec_rd.prefault_pf, rec_rd.fault_pf, rec_rd.pre_pf};
        hit = 1'b1;
      end
      `UPF_A_REC_INFO: begin
        rd = {10'h000, rec_rd.code, 1'b0, rec_rd.group, rec_rd.remain};
        hit = 1'b1;
      end
      default: ;
    endcase

    // zero wait state: ready follows every setup cycle
    next_s.pready = psel_i && !penable_i;
    if (psel_i && !penable_i) begin
      next_s.prdata = hit ? rd : 32'h0000_0000;
      next_s.pslverr = !hit;
    end else begin
      next_s.pslverr = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.mode <= MODE_ON;
      s.alarm_en <= `UPF_RST_ALARM_EN;
      s.trip_set <= `UPF_RST_TRIP_SET;
      s.alarm_set <= `UPF_RST_ALARM_SET;
      s.trip_dly <= `UPF_RST_DLY;
      s.alarm_dly <= `UPF_RST_DLY;
      s.evt_en <= `UPF_RST_EVT_EN;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign start_o = s.tr.run;
  assign trip_o = s.tr.done;
  assign blocked_o = s.blocked;
  assign alarm_start_o = s.al.run;
  assign alarm_o = s.al.done;
  assign evt_on_o = s.evt_on;
  assign evt_off_o = s.evt_off;
  assign evt_time_o = s.evt_time;
endmodule

/* verification/upf_props.sv */
// port checks for the under power factor stage
`timescale 1ns/1ps
module upf_props import upf_pkg::*; #(
  parameter int TICK_CYC = 8
) (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic block_i, // block in
  input wire logic [31:0] time_ms_i, // stamp in
  input wire logic pready_o, // apb ready
  input wire logic pslverr_o, // apb error
  input wire logic start_o, // start
  input wire logic trip_o, // trip
  input wire logic blocked_o, // blocked
  input wire logic [4:0] evt_on_o, // on pulses
  input wire logic [4:0] evt_off_o, // off pulses
  input wire logic [31:0] evt_time_o // stamp out
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // zero wait state slave: ready only right after a setup cycle
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("ready missing after setup");
  a_ready_only_access: assert property (pready_o |-> $past(psel_i) && !$past(penable_i))
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_trip_keeps_start: assert property (trip_o |-> start_o)
    else $error("trip without start");
  a_blocked_alone: assert property (blocked_o |-> !start_o && !trip_o)
    else $error("blocked with start");
  a_start_unblocked: assert property ($rose(start_o) |-> !$past(block_i))
    else $error("start under block");
  a_block_clears_start: assert property ($fell(start_o) && $past(block_i) |-> blocked_o)
    else $error("block did not replace start");
  a_evt_on_edge: assert property (evt_on_o[1] |-> $rose(start_o))
    else $error("start on event without edge");
  a_evt_off_edge: assert property (evt_off_o[2] |-> $fell(trip_o))
    else $error("trip off event without edge");
  a_evt_stamp: assert property ((|evt_on_o) || (|evt_off_o) |-> evt_time_o == $past(time_ms_i))
    else $error("event stamp wrong");
  a_evt_pulse: assert property (evt_on_o != 5'h00 |=> evt_on_o == 5'h00)
    else $error("event pulse too long");
  c_trip: cover property ($rose(trip_o));
  c_blocked: cover property ($rose(blocked_o));
  c_err: cover property (pslverr_o);
endmodule
bind under_power_factor_stage upf_props #(.TICK_CYC(TICK_CYC)) u_props (.clk_i(clk_i), .rstn_i(rstn_i),
  .psel_i(psel_i), .penable_i(penable_i), .block_i(block_i), .time_ms_i(time_ms_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .evt_on_o(evt_on_o),
  .evt_off_o(evt_off_o), .evt_time_o(evt_time_o));

/* verification/pf_source_model.sv */
// far side: blocking matrix and power factor measurement
`timescale 1ns/1ps
module pf_source_model (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, active low
  input wire logic want_block_i, // commanded block
  input wire logic [7:0] want_pf_i, // commanded power factor
  output logic block_o = 1'b0, // block to stage
  output logic [7:0] pf_o = 8'h60, // power factor to stage
  output logic [31:0] time_ms_o = 32'h0, // running time stamp
  output logic [2:0] sgroup_o = 3'h2 // setting group
);
  // block goes out at the next edge, far ahead of any delay expiry
  always @(posedge clk_i) begin
    block_o <= want_block_i;
    pf_o <= want_pf_i;
    time_ms_o <= rstn_i ? time_ms_o + 32'h1 : 32'h0;
  end
endmodule

/* verification/under_power_factor_stage_tb.sv */
// self-checking bench for the under power factor stage
`timescale 1ns/1ps
module under_power_factor_stage_tb;
  import upf_pkg::*;
  localparam int TICK = 8;
  logic clk_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0, want_block = 0, err;
  logic [7:0] paddr = 8'h00, want_pf = 8'h60, pf;
  logic [31:0] pwdata = 32'h0, prdata, rd, t0, tms, etime;
  logic pready, pslverr, block, start, trip, blocked, astart, alarm;
  logic [2:0] sg;
  logic [4:0] eon, eoff;
  wire logic [4:0] outs = {alarm, astart, blocked, trip, start};
  int fails = 0, n_compared = 0, n_on = 0, n_off = 0;
  under_power_factor_stage #(.TICK_CYC(TICK)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .block_i(block), .pf_i(pf), .time_ms_i(tms), .sgroup_i(sg),
    .start_o(start), .trip_o(trip), .blocked_o(blocked), .alarm_start_o(astart), .alarm_o(alarm),
    .evt_on_o(eon), .evt_off_o(eoff), .evt_time_o(etime));
  pf_source_model u_src (.clk_i(clk_i), .rstn_i(rstn_i), .want_block_i(want_block), .want_pf_i(want_pf),
    .block_o(block), .pf_o(pf), .time_ms_o(tms), .sgroup_o(sg));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // start event pulses, counted to see which edges get through
  always @(posedge clk_i) begin
    n_on += eon[1];
    n_off += eoff[1];
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", s, e, g);
      fails++;
    end
  endtask
  task finish_test;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one apb transfer; request held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk("apb ready", 1, 0);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rc(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  // bounded wait for one stage output to reach a level
  task wt(input int b, input logic v);
    int k;
    k = 0;
    while (outs[b] !== v && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) begin
      chk("stage output wait", v, outs[b]);
      finish_test();
    end
  endtask
  task ticks(input int n);
    repeat (n * TICK) @(posedge clk_i);
  endtask
  task do_reset;
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask
  task t_regs;
    rc("ctrl", 8'h00, 32'h8);
    rc("trip set", 8'h04, 32'h50);
    rc("alarm set", 8'h08, 32'h5A);
    rc("trip delay", 8'h0C, 32'h14);
    rc("event enables", 8'h14, 32'h3FF);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped error", 1, err);
    $display("t_regs done");
  endtask
  task t_modes;
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, 8'h00, m);
      rc("mode", 8'h18, m << 4);
    end
    apb(1'b1, 8'h00, 32'h7);
    rc("mode clipped", 8'h18, 32'h40);
    apb(1'b1, 8'h00, 32'h8);
    $display("t_modes done");
  endtask
  // pf between the two settings: alarm stage only, dropped once the alarm enable is cleared
  task t_alarm;
    want_pf <= 8'h55;
    wt(3, 1'b1);
    chk("start", 0, start);
    // the stage started on the latest tick, so no count has elapsed yet
    rc("remaining alarm", 8'h40, 32'h14);
    rc("expected alarm", 8'h3C, 32'h14);
    rc("ratio trip", 8'h44, 32'h6A);
    rc("ratio alarm", 8'h48, 32'h5E);
    wt(4, 1'b1);
    rc("condition", 8'h18, 32'h5);
    apb(1'b1, 8'h00, 32'h0);
    ticks(2);
    chk("alarm off", 2'b00, {astart, alarm});
    apb(1'b1, 8'h00, 32'h8);
    want_pf <= 8'h60;
    $display("t_alarm done");
  endtask
  task t_trip;
    int k;
    k = 0;
    apb(1'b1, 8'h0C, 32'h3);
    want_pf <= 8'h40;
    wt(0, 1'b1);
    while (trip !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    chk("trip after start", 3 * TICK, k);
    if (k >= 100) begin
      finish_test();
    end
    rc("expected op", 8'h34, 32'h3);
    rc("remaining trip", 8'h38, 32'h0);
    rc("ratio trip", 8'h44, 32'h50);
    rc("ratio alarm", 8'h48, 32'h47);
    want_pf <= 8'h52;
    ticks(3);
    chk("held inside band", 1, start);
    want_pf <= 8'h53;
    ticks(2);
    chk("released", 2'b00, {start, trip});
    want_pf <= 8'h60;
    $display("t_trip done");
  endtask
  task t_block;
    want_pf <= 8'h40;
    want_block <= 1'b1;
    wt(2, 1'b1);
    chk("start under block", 0, start);
    want_block <= 1'b0;
    wt(0, 1'b1);
    want_block <= 1'b1;
    wt(0, 1'b0);
    ticks(1);
    chk("blocked after start", 2'b10, {blocked, trip});
    want_block <= 1'b0;
    want_pf <= 8'h60;
    wt(2, 1'b0);
    // blocking mode acts as a standing block; pf is raised before the mode returns to on
    apb(1'b1, 8'h00, 32'h9);
    want_pf <= 8'h40;
    wt(2, 1'b1);
    chk("start in blocked mode", 0, start);
    want_pf <= 8'h60;
    apb(1'b1, 8'h00, 32'h8);
    wt(2, 1'b0);
    $display("t_block done");
  endtask
  // thirteen starts wrap the twelve slot store; only start OFF events enabled
  task t_store;
    do_reset();
    apb(1'b1, 8'h14, 32'h40);
    n_on = 0;
    n_off = 0;
    for (int i = 0; i < 13; i++) begin
      want_pf <= 8'h40;
      wt(0, 1'b1);
      want_pf <= 8'h60;
      wt(0, 1'b0);
    end
    ticks(1);
    chk("start on pulses", 0, n_on);
    chk("start off pulses", 13, n_off);
    rc("start count", 8'h24, 32'hD);
    apb(1'b1, 8'h4C, 32'h0);
    apb(1'b0, 8'h58, 32'h0);
    chk("record code", 2'h1, rd[21:20]);
    chk("record group", 3'h2, rd[18:16]);
    apb(1'b0, 8'h54, 32'h0);
    chk("record fault pf", 8'h40, rd[15:8]);
    // pf alternates each tick, so four ticks back is low again; forty ticks back predates reset
    chk("record pre pf", 8'h40, rd[7:0]);
    chk("record prefault pf", 8'h00, rd[23:16]);
    apb(1'b0, 8'h50, 32'h0);
    t0 = rd;
    apb(1'b1, 8'h4C, 32'hB);
    apb(1'b0, 8'h50, 32'h0);
    chk("oldest overwritten", 1, t0 > rd);
    apb(1'b1, 8'h1C, 32'h2);
    rc("start count cleared", 8'h24, 32'h0);
    $display("t_store done");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_modes();
    t_alarm();
    t_trip();
    t_block();
    t_store();
    finish_test();
  end
endmodule
